// *** design/rbcm_pkg.sv ***
// Constants for the readback command mux: register map, command codes,
// field positions, reset values and input encodings.
// Assumes a 32-bit APB master and a motion core that supplies live values.
//
// Overview of operation
// [RULE_01] Code 33h loads present ramp-up or ramp-down rate, 4 bytes.
// [RULE_02] Present ramp rate reads zero while no driving is in progress.
// [RULE_03] Linear constant-speed portion returns the programmed ramp-up rate.
// [RULE_04] Host ignores ramp-rate readback in S-curve constant-speed portion.
// [RULE_05] Codes 34h to 37h return general stores 0 to 3, signed 4 bytes.
// [RULE_06] Store readback shows the value a synchronous action last saved.
// [RULE_07] Code 38h returns running timer in microseconds, zero when stopped.
// [RULE_08] Codes 3Dh to 3Fh return config words one to three, 2 bytes.
// [RULE_09] Every 2-byte readback forces the high read-data register to zero.
// [RULE_10] Bus reads of config write registers never return their contents.
// [RULE_11] Code 40h returns the store-mode word last set by command 20h.
// [RULE_12] Codes 41h and 42h return pin-function words set by 21h, 22h.
// [RULE_13] Code 43h returns ramp-up rate last set by command 02h.
// [RULE_14] Ramp-up rate readback shows a value copied in from store 3.
// [RULE_15] Code 44h returns start velocity last set by command 04h.
// [RULE_16] Start velocity readback shows a value copied in from store 2.
// [RULE_17] Code 45h returns cruise velocity from command 05h or a store load.
// [RULE_18] Code 46h returns signed target count from 06h or a store load.
// [RULE_19] Command write loads 2-byte results low, 4-byte ones across both.
// [RULE_20] All readback values are binary, negatives in two's complement.
// [RULE_21] Host waits before reading the read-data registers after a command.
// [RULE_22] Low 16 bits go low, high 16 bits go high, both updated together.

`default_nettype none

package rbcm_pkg;

   // -------------------------------------------------------------
   // Register map (byte addresses)
   // -------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] A_COMMAND = 8'h00;
   localparam logic [7:0] A_DATA = 8'h04;
   localparam logic [7:0] A_CFG1 = 8'h08;
   localparam logic [7:0] A_CFG2 = 8'h0C;
   localparam logic [7:0] A_CFG3 = 8'h10;
   localparam logic [7:0] A_RD_LOW = 8'h14;
   localparam logic [7:0] A_RD_HIGH = 8'h18;

   // -------------------------------------------------------------
   // Command codes and field positions
   // -------------------------------------------------------------
   localparam int CODE_MSB = 7;
   localparam int HALF_W = 16;
   localparam logic [7:0] C_SET_RAMP = 8'h02;
   localparam logic [7:0] C_SET_START = 8'h04;
   localparam logic [7:0] C_SET_SPEED = 8'h05;
   localparam logic [7:0] C_SET_TARGET = 8'h06;
   localparam logic [7:0] C_SET_SMODE = 8'h20;
   localparam logic [7:0] C_SET_PIN1 = 8'h21;
   localparam logic [7:0] C_SET_PIN2 = 8'h22;
   localparam logic [7:0] C_RD_RATE = 8'h33;
   localparam logic [7:0] C_RD_STORE0 = 8'h34;
   localparam logic [7:0] C_RD_STORE1 = 8'h35;
   localparam logic [7:0] C_RD_STORE2 = 8'h36;
   localparam logic [7:0] C_RD_STORE3 = 8'h37;
   localparam logic [7:0] C_RD_TIMER = 8'h38;
   localparam logic [7:0] C_RD_CFG1 = 8'h3D;
   localparam logic [7:0] C_RD_CFG2 = 8'h3E;
   localparam logic [7:0] C_RD_CFG3 = 8'h3F;
   localparam logic [7:0] C_RD_SMODE = 8'h40;
   localparam logic [7:0] C_RD_PIN1 = 8'h41;
   localparam logic [7:0] C_RD_PIN2 = 8'h42;
   localparam logic [7:0] C_RD_RAMP = 8'h43;
   localparam logic [7:0] C_RD_START = 8'h44;
   localparam logic [7:0] C_RD_SPEED = 8'h45;
   localparam logic [7:0] C_RD_TARGET = 8'h46;

   // -------------------------------------------------------------
   // Input encodings and reset values
   // -------------------------------------------------------------
   localparam logic [2:0] PH_ACCEL = 3'h1;
   localparam logic [2:0] PH_CONST = 3'h2;
   localparam logic [2:0] PH_DECEL = 3'h4;
   localparam logic [1:0] LD_SPEED = 2'h0;
   localparam logic [1:0] LD_TARGET = 2'h1;
   localparam logic [1:0] LD_START = 2'h2;
   localparam logic [1:0] LD_RAMP = 2'h3;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [15:0] RST_HALF = 16'h0000;

endpackage

`default_nettype wire

// *** design/rbcm_top.sv ***
// Readback command mux: APB register slave, setting stores and the
// general stores, with the readback selector behind the command register.
// Assumes APB master on pclk and a motion core giving synchronous levels.
//
// Local design decisions: the placing of the registers and register access over APB.

`timescale 1ns/1ps
`default_nettype none

module rbcm_top #(
   parameter int DATA_W = 32,
   parameter int STORE_N = 4
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Live values from the motion core
   input wire logic drive_active,
   input wire logic [2:0] ramp_phase,
   input wire logic s_curve_mode,
   input wire logic [31:0] present_ramp_rate,
   input wire logic [31:0] running_timer_value,
   // Synchronous actions
   input wire logic [3:0] sync_save_valid,
   input wire logic [31:0] sync_save_value,
   input wire logic sync_load_valid,
   input wire logic [1:0] sync_load_kind,
   input wire logic [1:0] sync_load_src,
   // Settings towards the motion core
   output logic [31:0] ramp_up_rate,
   output logic [31:0] start_velocity,
   output logic [31:0] cruise_velocity,
   output logic [31:0] target_pulse_count,
   output logic [15:0] config_write_one,
   output logic [15:0] config_write_two,
   output logic [15:0] config_write_three,
   output logic [15:0] store_mode_config,
   output logic [15:0] pin_function_config_one,
   output logic [15:0] pin_function_config_two
);

   // ----------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------
   // The code map fixes four stores and 32-bit words
   if (DATA_W != 32 || STORE_N != 4) begin : g_bad_param
      $error("rbcm_top supports only DATA_W 32 and STORE_N 4");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [3:0][31:0] store;
      logic [31:0] ramp;
      logic [31:0] start;
      logic [31:0] speed;
      logic [31:0] target;
      logic [31:0] data_write;
      logic [15:0] cfg1;
      logic [15:0] cfg2;
      logic [15:0] cfg3;
      logic [15:0] smode;
      logic [15:0] pin1;
      logic [15:0] pin2;
      logic [15:0] rd_low;
      logic [15:0] rd_high;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } rbcm_state_s;

   rbcm_state_s r;
   rbcm_state_s next_r;

   // ----------------------------------------------------------------
   // Decoders
   // ----------------------------------------------------------------
   // Codes whose result is a single 16-bit word
   function automatic logic is_two_byte(input logic [7:0] code);
      is_two_byte = (code >= rbcm_pkg::C_RD_CFG1) &&
                    (code <= rbcm_pkg::C_RD_PIN2);
   endfunction

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == rbcm_pkg::A_COMMAND) || (a == rbcm_pkg::A_DATA) ||
                (a == rbcm_pkg::A_CFG1) || (a == rbcm_pkg::A_CFG2) ||
                (a == rbcm_pkg::A_CFG3) || (a == rbcm_pkg::A_RD_LOW) ||
                (a == rbcm_pkg::A_RD_HIGH);
   endfunction

   logic setup;
   logic done;
   logic cmd_fire;
   logic [7:0] code;
   assign setup = psel & ~penable;
   assign done = psel & penable & r.pready;
   assign cmd_fire = done & pwrite & ~r.pslverr &
                     (paddr == rbcm_pkg::A_COMMAND);
   assign code = pwdata[rbcm_pkg::CODE_MSB:0];

   // ----------------------------------------------------------------
   // Readback selector
   // ----------------------------------------------------------------
   // Settings and stores are taken from the registered state, so a result always
   // reflects settings as they stood before the command edge
   logic [31:0] rate_now;
   logic [31:0] rb;
   logic rb_hit;

   always_comb begin
      if (!drive_active) begin
         rate_now = rbcm_pkg::RST_WORD; // RULE_02
      end else if (ramp_phase == rbcm_pkg::PH_ACCEL ||
                   ramp_phase == rbcm_pkg::PH_DECEL) begin
         rate_now = present_ramp_rate; // RULE_01
      end else if (!s_curve_mode) begin
         rate_now = r.ramp; // RULE_03
      end else begin
         // Meaningless in the S-curve cruise; passed through as is
         rate_now = present_ramp_rate;
      end
   end

   always_comb begin
      rb = rbcm_pkg::RST_WORD;
      rb_hit = 1'b1;
      unique case (code)
         rbcm_pkg::C_RD_RATE: rb = rate_now; // RULE_01
         rbcm_pkg::C_RD_STORE0: rb = r.store[0]; // RULE_05
         rbcm_pkg::C_RD_STORE1: rb = r.store[1]; // RULE_05
         rbcm_pkg::C_RD_STORE2: rb = r.store[2]; // RULE_05
         rbcm_pkg::C_RD_STORE3: rb = r.store[3]; // RULE_05
         rbcm_pkg::C_RD_TIMER: begin
            rb = drive_active ? running_timer_value :
                 rbcm_pkg::RST_WORD; // RULE_07
         end
         rbcm_pkg::C_RD_CFG1: rb = {rbcm_pkg::RST_HALF, r.cfg1}; // RULE_08
         rbcm_pkg::C_RD_CFG2: rb = {rbcm_pkg::RST_HALF, r.cfg2}; // RULE_08
         rbcm_pkg::C_RD_CFG3: rb = {rbcm_pkg::RST_HALF, r.cfg3}; // RULE_08
         rbcm_pkg::C_RD_SMODE: rb = {rbcm_pkg::RST_HALF, r.smode}; // RULE_11
         rbcm_pkg::C_RD_PIN1: rb = {rbcm_pkg::RST_HALF, r.pin1}; // RULE_12
         rbcm_pkg::C_RD_PIN2: rb = {rbcm_pkg::RST_HALF, r.pin2}; // RULE_12
         rbcm_pkg::C_RD_RAMP: rb = r.ramp; // RULE_13
         rbcm_pkg::C_RD_START: rb = r.start; // RULE_15
         rbcm_pkg::C_RD_SPEED: rb = r.speed; // RULE_17
         rbcm_pkg::C_RD_TARGET: rb = r.target; // RULE_18 RULE_20
         default: rb_hit = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   logic [31:0] bus_rd;

   always_comb begin
      // Write-only locations answer zero so their contents stay hidden
      unique case (paddr)
         rbcm_pkg::A_DATA: bus_rd = r.data_write;
         rbcm_pkg::A_RD_LOW: bus_rd = {rbcm_pkg::RST_HALF, r.rd_low};
         rbcm_pkg::A_RD_HIGH: bus_rd = {rbcm_pkg::RST_HALF, r.rd_high};
         default: bus_rd = rbcm_pkg::RST_WORD; // RULE_10
      endcase
   end

   always_comb begin
      next_r = r;
      next_r.pready = 1'b0;
      next_r.pslverr = 1'b0;
      // One fixed wait-free answer: ready rises in the access cycle
      if (setup) begin
         next_r.pready = 1'b1;
         next_r.pslverr = ~addr_ok(paddr);
         next_r.prdata = pwrite ? rbcm_pkg::RST_WORD : bus_rd;
      end
      if (done && pwrite && !r.pslverr) begin
         unique case (paddr)
            rbcm_pkg::A_DATA: next_r.data_write = pwdata;
            rbcm_pkg::A_CFG1: next_r.cfg1 = pwdata[15:0];
            rbcm_pkg::A_CFG2: next_r.cfg2 = pwdata[15:0];
            rbcm_pkg::A_CFG3: next_r.cfg3 = pwdata[15:0];
            default: ;
         endcase
      end
      // Setting commands take their value from the data register
      if (cmd_fire) begin
         unique case (code)
            rbcm_pkg::C_SET_RAMP: next_r.ramp = r.data_write; // RULE_13
            rbcm_pkg::C_SET_START: next_r.start = r.data_write; // RULE_15
            rbcm_pkg::C_SET_SPEED: next_r.speed = r.data_write; // RULE_17
            rbcm_pkg::C_SET_TARGET: next_r.target = r.data_write; // RULE_18
            rbcm_pkg::C_SET_SMODE: begin
               next_r.smode = r.data_write[15:0]; // RULE_11
            end
            rbcm_pkg::C_SET_PIN1: next_r.pin1 = r.data_write[15:0]; // RULE_12
            rbcm_pkg::C_SET_PIN2: next_r.pin2 = r.data_write[15:0]; // RULE_12
            default: ;
         endcase
         // Both halves move on one edge so a reader never sees a mix
         if (rb_hit) begin
            next_r.rd_low = rb[rbcm_pkg::HALF_W-1:0]; // RULE_19 RULE_22
            next_r.rd_high = is_two_byte(code) ? rbcm_pkg::RST_HALF :
                             rb[31:rbcm_pkg::HALF_W]; // RULE_09 RULE_22
         end
      end
      // Synchronous saves into the stores
      for (int i = 0; i < 4; i++) begin
         if (sync_save_valid[i]) begin
            next_r.store[i] = sync_save_value; // RULE_06
         end
      end
      // A store load beats a host setting on the same edge
      if (sync_load_valid) begin
         unique case (sync_load_kind)
            rbcm_pkg::LD_SPEED: begin
               next_r.speed = r.store[sync_load_src]; // RULE_17
            end
            rbcm_pkg::LD_TARGET: begin
               next_r.target = r.store[sync_load_src]; // RULE_18
            end
            rbcm_pkg::LD_START: next_r.start = r.store[2]; // RULE_16
            rbcm_pkg::LD_RAMP: next_r.ramp = r.store[3]; // RULE_14
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from the state flops
   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign ramp_up_rate = r.ramp;
   assign start_velocity = r.start;
   assign cruise_velocity = r.speed;
   assign target_pulse_count = r.target;
   assign config_write_one = r.cfg1;
   assign config_write_two = r.cfg2;
   assign config_write_three = r.cfg3;
   assign store_mode_config = r.smode;
   assign pin_function_config_one = r.pin1;
   assign pin_function_config_two = r.pin2;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_rd_cmd(logic [7:0] c);
      cmd_fire && code == c;
   endsequence

   sequence s_apb_setup;
      psel && !penable;
   endsequence

   a_ready_one_cycle: assert property (
      s_apb_setup |=> pready ##1 !pready)
      else $error("pready not a single access-cycle pulse");

   a_rate_idle_zero: assert property ( // RULE_02
      s_rd_cmd(rbcm_pkg::C_RD_RATE) ##0 !drive_active
      |=> {r.rd_high, r.rd_low} == 32'h0000_0000)
      else $error("ramp rate not zero while stopped");

   a_rate_cruise_set: assert property ( // RULE_03
      s_rd_cmd(rbcm_pkg::C_RD_RATE) ##0 drive_active ##0
      (ramp_phase == rbcm_pkg::PH_CONST) ##0 !s_curve_mode
      |=> {r.rd_high, r.rd_low} == $past(r.ramp))
      else $error("linear cruise does not return ramp-up setting");

   a_rate_live: assert property ( // RULE_01
      s_rd_cmd(rbcm_pkg::C_RD_RATE) ##0 drive_active ##0
      (ramp_phase == rbcm_pkg::PH_DECEL)
      |=> {r.rd_high, r.rd_low} == $past(present_ramp_rate))
      else $error("present ramp rate not loaded");

   a_store_two_read: assert property ( // RULE_05
      s_rd_cmd(rbcm_pkg::C_RD_STORE2)
      |=> {r.rd_high, r.rd_low} == $past(r.store[2]))
      else $error("store 2 readback wrong");

   a_timer_idle_zero: assert property ( // RULE_07
      s_rd_cmd(rbcm_pkg::C_RD_TIMER) ##0 !drive_active
      |=> r.rd_high == 16'h0000 && r.rd_low == 16'h0000)
      else $error("timer not zero while stopped");

   a_short_high_zero: assert property ( // RULE_09
      cmd_fire && is_two_byte(code) |=> r.rd_high == 16'h0000)
      else $error("high half not cleared on 2-byte read");

   a_cfg_read_back: assert property ( // RULE_08
      s_rd_cmd(rbcm_pkg::C_RD_CFG2) |=> r.rd_low == $past(r.cfg2))
      else $error("config two readback wrong");

   a_cfg_bus_hidden: assert property ( // RULE_10
      s_apb_setup ##0 !pwrite ##0 (paddr == rbcm_pkg::A_CFG1)
      |=> prdata == 32'h0000_0000)
      else $error("config word visible on bus read");

   a_ramp_store_load: assert property ( // RULE_14
      sync_load_valid && sync_load_kind == rbcm_pkg::LD_RAMP
      |=> ramp_up_rate == $past(r.store[3]))
      else $error("store 3 not copied into ramp-up rate");

   a_save_store: assert property ( // RULE_06
      sync_save_valid[1] |=> r.store[1] == $past(sync_save_value))
      else $error("synchronous save lost");

endmodule

`default_nettype wire

// *** tb/rbcm_host_model.sv ***
// Host model: APB master that writes command codes and reads results.
// Assumes a slave on pclk that answers each access phase with pready.
`timescale 1ns/1ps
`default_nettype none
module rbcm_host_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB master side
   output logic [7:0] paddr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // Idle bus from time zero
   initial begin
      paddr = 8'h00;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      pwdata = 32'h0000_0000;
   end

   // One transfer, held until pready is sampled high; the bench bounds it
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No cycle count is assumed; only the bench watchdog ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines flip so stale data is never taken for an answer
      paddr <= ~a;
      pwdata <= ~d;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      xfer(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] r,
      output logic e);
      xfer(1'b0, a, 32'h0000_0000, r, e);
   endtask

   // Command write; results are read only after a later setup cycle
   task automatic cmd(input logic [7:0] code);
      wr(rbcm_pkg::A_COMMAND, {24'h00_0000, code});
   endtask
endmodule
`default_nettype wire

// *** tb/rbcm_top_tb.sv ***
// Testbench for the readback mux: host model on APB, live motion values
// and synchronous actions driven here. Assumes the design's package.
`timescale 1ns/1ps
`default_nettype none
module rbcm_top_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic drive_active, s_curve_mode, sync_load_valid;
   logic [2:0] ramp_phase;
   logic [31:0] present_ramp_rate, running_timer_value, sync_save_value;
   logic [3:0] sync_save_valid;
   logic [1:0] sync_load_kind, sync_load_src;
   logic [31:0] ramp_up_rate, start_velocity, cruise_velocity;
   logic [31:0] target_pulse_count;
   logic [15:0] cfg1, cfg2, cfg3, smode, pin1, pin2;
   int bad_count = 0;
   int n_checks = 0;

   rbcm_host_model host (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));

   rbcm_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .drive_active(drive_active), .ramp_phase(ramp_phase),
      .s_curve_mode(s_curve_mode), .present_ramp_rate(present_ramp_rate),
      .running_timer_value(running_timer_value),
      .sync_save_valid(sync_save_valid), .sync_save_value(sync_save_value),
      .sync_load_valid(sync_load_valid), .sync_load_kind(sync_load_kind),
      .sync_load_src(sync_load_src), .ramp_up_rate(ramp_up_rate),
      .start_velocity(start_velocity), .cruise_velocity(cruise_velocity),
      .target_pulse_count(target_pulse_count), .config_write_one(cfg1),
      .config_write_two(cfg2), .config_write_three(cfg3),
      .store_mode_config(smode), .pin_function_config_one(pin1),
      .pin_function_config_two(pin2));

   // 100 MHz clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // --------------------------------------------------------------
   // Checking helpers
   // --------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Issue a readback code, then read both halves back to back
   task automatic rdback(input logic [7:0] code, input logic [31:0] exp);
      logic [31:0] lo, hi;
      logic e;
      host.cmd(code);
      host.rd(rbcm_pkg::A_RD_LOW, lo, e);
      host.rd(rbcm_pkg::A_RD_HIGH, hi, e);
      chk("result", {hi[15:0], lo[15:0]}, exp);
      chk("upper bits", {hi[31:16], lo[31:16]}, 32'h0000_0000);
      chk("read error", {31'h0, e}, 32'h0000_0000);
   endtask

   // Store i is loaded with a distinct negative value
   function automatic logic [31:0] store_val(input int i);
      return 32'h8000_0001 + 32'h0101_0000 * i;
   endfunction

   task automatic motion(input logic act, input logic [2:0] ph,
      input logic s);
      @(posedge pclk);
      drive_active <= act;
      ramp_phase <= ph;
      s_curve_mode <= s;
   endtask

   // --------------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------------
   task automatic t_reset();
      logic [7:0] wo [4] = '{8'h00, 8'h08, 8'h0C, 8'h10};
      logic [31:0] r;
      logic e;
      chk("ramp_up_rate", ramp_up_rate, 32'h0000_0000);
      chk("target", target_pulse_count, 32'h0000_0000);
      foreach (wo[i]) begin
         host.rd(wo[i], r, e);
         chk("write-only read", r, 32'h0000_0000);
      end
      rdback(rbcm_pkg::C_RD_SPEED, 32'h0000_0000);
   endtask

   task automatic t_settings();
      logic [7:0] sc [7] = '{8'h02, 8'h04, 8'h05, 8'h06, 8'h20, 8'h21,
         8'h22};
      logic [7:0] rc [7] = '{8'h43, 8'h44, 8'h45, 8'h46, 8'h40, 8'h41,
         8'h42};
      logic [31:0] v [7] = '{32'h1234_5678, 32'h0007_A120, 32'h007A_1200,
         32'hFFFF_FF85, 32'hABCD_1357, 32'h5555_2468, 32'hFFFF_9BDF};
      logic [31:0] want;
      foreach (sc[i]) begin
         host.wr(rbcm_pkg::A_DATA, v[i]);
         host.cmd(sc[i]);
         // A 2-byte code follows a negative 4-byte one: high must clear
         want = i < 4 ? v[i] : {16'h0000, v[i][15:0]};
         rdback(rc[i], want);
      end
      chk("start port", start_velocity, v[1]);
      chk("pin2 port", {16'h0000, pin2}, 32'h0000_9BDF);
      chk("ramp port", ramp_up_rate, v[0]);
      chk("cruise port", cruise_velocity, v[2]);
      chk("target port", target_pulse_count, v[3]);
      chk("smode port", {16'h0000, smode}, 32'h0000_1357);
      chk("pin1 port", {16'h0000, pin1}, 32'h0000_2468);
   endtask

   task automatic t_config();
      logic [7:0] a [3] = '{8'h08, 8'h0C, 8'h10};
      logic [7:0] rc [3] = '{8'h3D, 8'h3E, 8'h3F};
      logic [31:0] r;
      logic e;
      foreach (a[i]) begin
         host.wr(a[i], 32'hFFFF_A5A0 + i);
         host.rd(a[i], r, e);
         chk("config bus read", r, 32'h0000_0000);
         rdback(rbcm_pkg::C_RD_TARGET, 32'hFFFF_FF85);
         rdback(rc[i], 32'h0000_A5A0 + i);
      end
      chk("config three port", {16'h0000, cfg3}, 32'h0000_A5A2);
      chk("config one port", {16'h0000, cfg1}, 32'h0000_A5A0);
      chk("config two port", {16'h0000, cfg2}, 32'h0000_A5A1);
   endtask

   task automatic t_stores();
      logic [1:0] kd [4] = '{2'h3, 2'h2, 2'h0, 2'h1};
      logic [1:0] src [4] = '{2'h0, 2'h0, 2'h1, 2'h0};
      logic [7:0] rc [4] = '{8'h43, 8'h44, 8'h45, 8'h46};
      int ix [4] = '{3, 2, 1, 0};
      for (int i = 0; i < 4; i++) begin
         @(posedge pclk);
         sync_save_valid <= 4'h1 << i;
         sync_save_value <= store_val(i);
         @(posedge pclk);
         sync_save_valid <= 4'h0;
         rdback(8'h34 + i, store_val(i));
      end
      foreach (kd[i]) begin
         @(posedge pclk);
         sync_load_valid <= 1'b1;
         sync_load_kind <= kd[i];
         sync_load_src <= src[i];
         @(posedge pclk);
         sync_load_valid <= 1'b0;
         rdback(rc[i], store_val(ix[i]));
      end
   endtask

   task automatic t_rate();
      @(posedge pclk);
      present_ramp_rate <= 32'h0001_E240;
      running_timer_value <= 32'h0000_3039;
      motion(1'b0, rbcm_pkg::PH_ACCEL, 1'b0);
      rdback(rbcm_pkg::C_RD_RATE, 32'h0000_0000);
      rdback(rbcm_pkg::C_RD_TIMER, 32'h0000_0000);
      motion(1'b1, rbcm_pkg::PH_ACCEL, 1'b0);
      rdback(rbcm_pkg::C_RD_RATE, 32'h0001_E240);
      rdback(rbcm_pkg::C_RD_TIMER, 32'h0000_3039);
      motion(1'b1, rbcm_pkg::PH_DECEL, 1'b1);
      rdback(rbcm_pkg::C_RD_RATE, 32'h0001_E240);
      motion(1'b1, rbcm_pkg::PH_CONST, 1'b0);
      rdback(rbcm_pkg::C_RD_RATE, store_val(3));
      // S-curve constant speed is not judged: the value is meaningless
      motion(1'b1, rbcm_pkg::PH_CONST, 1'b1);
      motion(1'b0, rbcm_pkg::PH_CONST, 1'b0);
   endtask

   task automatic t_refuse();
      logic [31:0] lo, hi;
      logic e;
      host.wr(8'h1C, 32'hFFFF_FFFF);
      host.rd(8'h1C, lo, e);
      chk("unmapped data", lo, 32'h0000_0000);
      chk("unmapped error", {31'h0, e}, 32'h0000_0001);
      rdback(rbcm_pkg::C_RD_STORE1, store_val(1));
      host.cmd(8'h7F);
      host.rd(rbcm_pkg::A_RD_LOW, lo, e);
      host.rd(rbcm_pkg::A_RD_HIGH, hi, e);
      chk("kept result", {hi[15:0], lo[15:0]}, store_val(1));
   endtask

   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Watchdog: the whole run needs a few hundred cycles
   initial begin
      #100000;
      bad_count++;
      end_sim();
   end

   // Main sequence: reset for six cycles, then the scenarios
   initial begin
      presetn = 1'b0;
      drive_active = 1'b0;
      ramp_phase = 3'h0;
      s_curve_mode = 1'b0;
      present_ramp_rate = 32'h0000_0000;
      running_timer_value = 32'h0000_0000;
      sync_save_valid = 4'h0;
      sync_save_value = 32'h0000_0000;
      sync_load_valid = 1'b0;
      sync_load_kind = 2'h0;
      sync_load_src = 2'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_settings();
      t_config();
      t_stores();
      t_rate();
      t_refuse();
      end_sim();
   end
endmodule
`default_nettype wire
